/* File: src/pdat_pkg.sv */
// Package for the power and conversion trigger register bank.
// Assumes an APB slave with 32-bit data, one 8-bit register per byte address.
package pdat_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [ADDR_W-1:0] UPPER_DAC_PWR_OFS = 8'hb3;
    localparam logic [ADDR_W-1:0] CORE_PWR_OFS = 8'hb4;
    localparam logic [ADDR_W-1:0] CONV_TRIG_OFS = 8'hc0;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam int ADC_PWR_BIT = 0;
    localparam int REF_PWR_BIT = 1;
    localparam int TRIG_BIT = 0;
    localparam logic [REG_W-1:0] CORE_PWR_MASK = 8'h03;
    localparam logic [REG_W-1:0] TRIG_MASK = 8'h01;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
    localparam int UPPER_CHAN_BASE = 8;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_REQUEST = 2'b01,
        CONV_BUSY = 2'b10
    } pdat_conv_state_type;
endpackage : pdat_pkg

/* File: src/pdat_trig_if.sv */
// Interface carrying the conversion trigger between the register file and the sequencer.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface pdat_trig_if;
    logic trigReq;
    logic convStarted;
    logic convBusy;
    modport regs (output trigReq, input convStarted, input convBusy);
    modport seq (input trigReq, output convStarted, output convBusy);
endinterface : pdat_trig_if
`default_nettype wire

/* File: src/pdat_conv_seq.sv */
// Conversion start sequencer: turns a trigger request into a start pulse.
// Assumes the engine answers with a done level; ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module pdat_conv_seq
    import pdat_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic adcPowered,
    input wire logic convDone,
    output logic convStart,
    pdat_trig_if.seq trig
);
    pdat_conv_state_type state_reg;
    pdat_conv_state_type state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CONV_IDLE: begin
                if (trig.trigReq && adcPowered) begin
                    state_next = CONV_REQUEST;
                end
            end
            CONV_REQUEST: state_next = CONV_BUSY;
            CONV_BUSY: begin
                if (convDone || !adcPowered) begin
                    state_next = CONV_IDLE;
                end
            end
            default: state_next = CONV_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CONV_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Start pulse registered from the next state and driven out on the convStart output
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            convStart <= 1'b0;
        end else begin
            convStart <= (state_next == CONV_REQUEST);
        end
    end

    assign trig.convStarted = (state_reg == CONV_REQUEST);
    assign trig.convBusy = (state_reg != CONV_IDLE);

    a_start_follows_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg == CONV_IDLE && trig.trigReq && adcPowered) |=> convStart)
        else $error("conversion start missing after trigger");
endmodule : pdat_conv_seq
`default_nettype wire

/* File: src/pdat_power_regs.sv */
// Power enable and conversion trigger register bank behind an APB slave.
// Assumes a single ref_clk domain and an external conversion engine with done level.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Reset clears all power and trigger bits to zero.
// - A written 1 enables the function; 0 keeps it inactive.
// - DAC channel with power bit zero stays clamped.
// - ADC and reference stay in low-power mode while their bit is zero.
// - Upper DAC register bit 7 is channel 15 down to bit 0 channel 8.
// - Core register bit 1 reference, bit 0 ADC, bits 7-2 reserved zero.
// - Trigger register resets to zero, only bit 0 functional.
// - Writing 1 to the trigger starts a conversion internally.
// - Trigger bit clears itself once the conversion begins.
// - Upper DAC power register sits at 0xB3, reset zero.
module pdat_power_regs
    import pdat_pkg::*;
#(
    parameter int NUM_UPPER_DAC = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pdat_pkg::ADDR_W-1:0] paddr,
    input wire logic [pdat_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [pdat_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic convDone,
    output logic [NUM_UPPER_DAC-1:0] dacOutEnable,
    output logic [NUM_UPPER_DAC-1:0] dacClamp,
    output logic converterPowerEnable,
    output logic referencePowerEnable,
    output logic convStart,
    output logic convBusy
);
    import pdat_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [REG_W-1:0] upperDacPwr_reg;
    logic [REG_W-1:0] corePwr_reg;
    logic [REG_W-1:0] convTrig_reg;
    logic convDoneSync1_reg;
    logic convDoneSync2_reg;
    logic convStartInt;
    logic access;
    logic wrLane0;
    logic [DATA_W-1:0] rdata_next;
    logic mapped;
    logic trigSetWr;

    pdat_trig_if trigLink();

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : addr_hit

    assign access = psel && penable && pready;
    assign wrLane0 = access && pwrite && pstrb[0];
    assign trigSetWr = wrLane0 && addr_hit(paddr, CONV_TRIG_OFS) && pwdata[TRIG_BIT];
    assign mapped = addr_hit(paddr, UPPER_DAC_PWR_OFS) || addr_hit(paddr, CORE_PWR_OFS)
        || addr_hit(paddr, CONV_TRIG_OFS);

    always_comb begin
        if (addr_hit(paddr, UPPER_DAC_PWR_OFS)) begin
            rdata_next = {{(DATA_W-REG_W){1'b0}}, upperDacPwr_reg};
        end else if (addr_hit(paddr, CORE_PWR_OFS)) begin
            rdata_next = {{(DATA_W-REG_W){1'b0}}, corePwr_reg};
        end else if (addr_hit(paddr, CONV_TRIG_OFS)) begin
            rdata_next = {{(DATA_W-REG_W){1'b0}}, convTrig_reg};
        end else begin
            rdata_next = READ_ZERO;
        end
    end

    // No wait state: pready rises in the access phase's first cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= READ_ZERO;
            pslverr <= 1'b0;
        end else begin
            if (psel && !penable) begin
                prdata <= pwrite ? READ_ZERO : rdata_next;
                pslverr <= !mapped;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power registers

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            upperDacPwr_reg <= REG_RESET;
        end else if (wrLane0 && addr_hit(paddr, UPPER_DAC_PWR_OFS)) begin
            upperDacPwr_reg <= pwdata[REG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            corePwr_reg <= REG_RESET;
        end else if (wrLane0 && addr_hit(paddr, CORE_PWR_OFS)) begin
            corePwr_reg <= pwdata[REG_W-1:0] & CORE_PWR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger register

    // A set write wins over the self-clear on start; a write of 0 is ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            convTrig_reg <= REG_RESET;
        end else if (trigSetWr) begin
            convTrig_reg <= TRIG_MASK;
        end else if (trigLink.convStarted) begin
            convTrig_reg <= REG_RESET;
        end
    end

    assign trigLink.trigReq = convTrig_reg[TRIG_BIT] && !trigLink.convStarted;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            convDoneSync1_reg <= 1'b0;
            convDoneSync2_reg <= 1'b0;
        end else begin
            convDoneSync1_reg <= convDone;
            convDoneSync2_reg <= convDoneSync1_reg;
        end
    end

    pdat_conv_seq u_seq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .adcPowered(corePwr_reg[ADC_PWR_BIT]),
        .convDone(convDoneSync2_reg),
        .convStart(convStartInt),
        .trig(trigLink.seq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Analog control and conversion start/busy outputs

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dacOutEnable <= '0;
            dacClamp <= '1;
            converterPowerEnable <= 1'b0;
            referencePowerEnable <= 1'b0;
            convStart <= 1'b0;
            convBusy <= 1'b0;
        end else begin
            dacOutEnable <= upperDacPwr_reg[NUM_UPPER_DAC-1:0];
            dacClamp <= ~upperDacPwr_reg[NUM_UPPER_DAC-1:0];
            converterPowerEnable <= corePwr_reg[ADC_PWR_BIT];
            referencePowerEnable <= corePwr_reg[REF_PWR_BIT];
            convStart <= convStartInt;
            convBusy <= trigLink.convBusy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_trig_write;
        trigSetWr;
    endsequence

    sequence s_conv_launch;
        s_trig_write ##1 (corePwr_reg[ADC_PWR_BIT] && !trigLink.convBusy);
    endsequence

    sequence s_upper_write;
        wrLane0 && addr_hit(paddr, UPPER_DAC_PWR_OFS);
    endsequence

    sequence s_core_write;
        wrLane0 && addr_hit(paddr, CORE_PWR_OFS);
    endsequence

    sequence s_zero_trig_write;
        wrLane0 && addr_hit(paddr, CONV_TRIG_OFS) && !pwdata[TRIG_BIT];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // Register and output checks

    a_clamp_tracks_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 dacClamp == ~$past(upperDacPwr_reg[NUM_UPPER_DAC-1:0]))
        else $error("clamp not inverse of power bits");

    a_dac_enable_tracks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 dacOutEnable == $past(upperDacPwr_reg[NUM_UPPER_DAC-1:0]))
        else $error("dac enables differ from power bits");

    a_upper_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_upper_write |=> upperDacPwr_reg == $past(pwdata[REG_W-1:0]))
        else $error("upper dac power write lost");

    a_core_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_core_write |=> corePwr_reg == ($past(pwdata[REG_W-1:0]) & CORE_PWR_MASK))
        else $error("core power write lost");

    a_core_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (corePwr_reg & ~CORE_PWR_MASK) == REG_RESET)
        else $error("reserved core bits set");

    a_trig_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (convTrig_reg & ~TRIG_MASK) == REG_RESET)
        else $error("reserved trigger bits set");

    a_adc_off_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !corePwr_reg[ADC_PWR_BIT] |=> !converterPowerEnable)
        else $error("adc powered with bit zero");

    a_ref_off_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !corePwr_reg[REF_PWR_BIT] |=> !referencePowerEnable)
        else $error("reference powered with bit zero");

    a_adc_on_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        corePwr_reg[ADC_PWR_BIT] |=> converterPowerEnable)
        else $error("adc not enabled");

    a_ref_on_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        corePwr_reg[REF_PWR_BIT] |=> referencePowerEnable)
        else $error("reference not enabled");

    ////////////////////////////////////////////////////////////////////////////
    // Trigger checks

    a_trig_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_trig_write |=> convTrig_reg[TRIG_BIT])
        else $error("trigger bit not set by write");

    a_launch_on_trig: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_conv_launch |=> trigLink.convStarted)
        else $error("conversion not launched by trigger");

    a_trig_self_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (trigLink.convStarted && !trigSetWr) |=> !convTrig_reg[TRIG_BIT])
        else $error("trigger bit did not clear");

    a_pending_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (convTrig_reg[TRIG_BIT] && !corePwr_reg[ADC_PWR_BIT] && !trigLink.convStarted)
        |=> convTrig_reg[TRIG_BIT])
        else $error("pending trigger lost");

    a_start_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        convStart |=> !convStart)
        else $error("start pulse longer than one cycle");

    a_no_start_unpowered: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !corePwr_reg[ADC_PWR_BIT] |=> !convStartInt)
        else $error("conversion started with adc off");

    a_zero_write_inert: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (s_zero_trig_write ##0 (!convTrig_reg[TRIG_BIT] && !convDoneSync2_reg
        && corePwr_reg[ADC_PWR_BIT])) |=> !convTrig_reg[TRIG_BIT] && $stable(trigLink.convBusy))
        else $error("zero write changed trigger");

    ////////////////////////////////////////////////////////////////////////////
    // Bus and reset checks

    a_lane_off_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && pwrite && !pstrb[0]) |=> $stable(upperDacPwr_reg) && $stable(corePwr_reg))
        else $error("write without low lane landed");

    a_unmapped_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && pwrite && !mapped) |=> $stable(upperDacPwr_reg) && $stable(corePwr_reg))
        else $error("unmapped write landed");

    a_unmapped_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (psel && !penable && !mapped) |=> pslverr)
        else $error("unmapped access without error");

    a_upper_read_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && addr_hit(paddr, UPPER_DAC_PWR_OFS))
        |=> prdata == {{(DATA_W-REG_W){1'b0}}, $past(upperDacPwr_reg)})
        else $error("upper dac power read wrong");

    a_reset_release_zero: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> upperDacPwr_reg == REG_RESET && corePwr_reg == REG_RESET
        && convTrig_reg == REG_RESET)
        else $error("registers not zero after reset");

    a_reset_outputs_off: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> dacClamp == '1 && dacOutEnable == '0 && !converterPowerEnable
        && !referencePowerEnable && !convBusy)
        else $error("outputs not off after reset");
endmodule : pdat_power_regs
`default_nettype wire

/* File: tb/power_down_and_adc_trigger_regs_tb_top.sv */
// Self-checking bench for the power enable and conversion trigger bank.
// Assumes pdat_pkg and the design files are compiled first; bench is the APB master.
`timescale 1ns/1ps
`default_nettype none
module power_down_and_adc_trigger_regs_tb_top;
    import pdat_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic convDone = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'h0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, converterPowerEnable, referencePowerEnable, convStart, convBusy;
    logic [7:0] dacOutEnable, dacClamp, v;
    logic [DATA_W-1:0] rd;
    logic er;
    int errorCnt = 0;
    int samplesChecked = 0;
    int startCnt = 0;

    pdat_power_regs #(.NUM_UPPER_DAC(8)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .convDone(convDone),
        .dacOutEnable(dacOutEnable), .dacClamp(dacClamp),
        .converterPowerEnable(converterPowerEnable),
        .referencePowerEnable(referencePowerEnable), .convStart(convStart), .convBusy(convBusy));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (convStart === 1'b1) startCnt++;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errorCnt++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] expCore(input logic [7:0] d);
        return {24'h00_0000, d & CORE_PWR_MASK};
    endfunction : expCore

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), d};
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic ee);
        apb(1'b0, a, 8'h00, 4'h0);
        chk(rd, {24'h00_0000, e});
        chk(32'(er), 32'(ee));
    endtask : rdchk

    task automatic outs(input logic [7:0] d, input logic [31:0] c);
        chk(32'(dacOutEnable), 32'(d));
        chk(32'(dacClamp), {24'h00_0000, ~d});
        chk(32'(converterPowerEnable), 32'(c[ADC_PWR_BIT]));
        chk(32'(referencePowerEnable), 32'(c[REF_PWR_BIT]));
    endtask : outs

    task automatic waitStart(input int e);
        for (int n = 0; n < 20 && startCnt != e; n++) @(posedge ref_clk);
        chk(32'(startCnt), 32'(e));
    endtask : waitStart

    task automatic finishConv();
        convDone <= 1'b1;
        for (int n = 0; n < 20 && convBusy !== 1'b0; n++) @(posedge ref_clk);
        chk(32'(convBusy), 32'h0000_0000);
        convDone <= 1'b0;
    endtask : finishConv

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0a94_4748));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk(UPPER_DAC_PWR_OFS, REG_RESET, 1'b0);
        rdchk(CORE_PWR_OFS, REG_RESET, 1'b0);
        rdchk(CONV_TRIG_OFS, REG_RESET, 1'b0);
        outs(8'h00, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : (i == 2) ? 8'h01 : 8'($urandom);
            wr(UPPER_DAC_PWR_OFS, v);
            wr(CORE_PWR_OFS, ~v);
            rdchk(UPPER_DAC_PWR_OFS, v, 1'b0);
            rdchk(CORE_PWR_OFS, 8'(expCore(~v)), 1'b0);
            outs(v, expCore(~v));
        end
        $display("power enable test done");
        apb(1'b1, UPPER_DAC_PWR_OFS, ~v, 4'he);
        rdchk(UPPER_DAC_PWR_OFS, v, 1'b0);
        apb(1'b1, 8'hb5, 8'hff, 4'hf);
        chk(32'(er), 32'h0000_0001);
        rdchk(8'hb5, 8'h00, 1'b1);
        $display("refusal test done");
        wr(CORE_PWR_OFS, 8'h01);
        wr(CONV_TRIG_OFS, 8'hff);
        waitStart(1);
        chk(32'(convBusy), 32'h0000_0001);
        rdchk(CONV_TRIG_OFS, 8'h00, 1'b0);
        wr(CONV_TRIG_OFS, 8'h00);
        repeat (4) @(posedge ref_clk);
        chk(32'(convBusy), 32'h0000_0001);
        finishConv();
        chk(32'(startCnt), 32'h0000_0001);
        $display("trigger test done");
        wr(CORE_PWR_OFS, 8'h00);
        wr(CONV_TRIG_OFS, 8'h01);
        repeat (6) @(posedge ref_clk);
        rdchk(CONV_TRIG_OFS, 8'h01, 1'b0);
        chk(32'(startCnt), 32'h0000_0001);
        wr(CORE_PWR_OFS, 8'h01);
        waitStart(2);
        rdchk(CONV_TRIG_OFS, 8'h00, 1'b0);
        finishConv();
        $display("pending trigger test done");
        wr(CONV_TRIG_OFS, 8'h01);
        waitStart(3);
        chk(32'(convBusy), 32'h0000_0001);
        wr(CORE_PWR_OFS, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk(32'(convBusy), 32'h0000_0000);
        chk(32'(startCnt), 32'h0000_0003);
        $display("power off test done");
        v = 8'($urandom) | 8'h01;
        wr(UPPER_DAC_PWR_OFS, v);
        wr(CORE_PWR_OFS, 8'h03);
        repeat (2) @(posedge ref_clk);
        outs(v, 32'h0000_0003);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk(UPPER_DAC_PWR_OFS, REG_RESET, 1'b0);
        rdchk(CORE_PWR_OFS, REG_RESET, 1'b0);
        outs(8'h00, 32'h0000_0000);
        $display("mid-run reset test done");
        close_out();
    end
endmodule : power_down_and_adc_trigger_regs_tb_top
`default_nettype wire
